/* File: design/pmc_pkg.sv */
// constants shared by the phy mode control block
// assumes a 250 MHz core clock and a 32-bit avalon-mm register port
package pmc_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BLINK20_HALF_US = 25000; // half of a 20 Hz period
  localparam int FLP_BIT_US = 125; // clock pulse to clock pulse
  localparam int FLP_BURST_US = 16000; // burst to burst
  localparam int BLINK_CYC = BLINK20_HALF_US * CLK_MHZ;
  localparam int FLP_BIT_CYC = FLP_BIT_US * CLK_MHZ;
  localparam int FLP_BURST_CYC = FLP_BURST_US * CLK_MHZ;
  localparam int STRAP_CNT = 3; // reload count; straps taken at one, after the two sync stages refill
  // ------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_CTL = 6'h00;
  localparam logic [5:0] IDX_STS = 6'h01;
  localparam logic [5:0] IDX_ADV = 6'h04;
  localparam logic [5:0] IDX_LPA = 6'h05;
  localparam logic [5:0] IDX_MODE = 6'h10;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL_RST = 15;
  localparam int CTL_SPD = 13;
  localparam int CTL_ANE = 12;
  localparam int CTL_PDN = 11;
  localparam int CTL_DUP = 8;
  localparam int STS_PRE = 6;
  localparam int STS_ANC = 5;
  localparam int STS_RF = 4;
  localparam int STS_LNK = 2;
  localparam int CW_RF = 13;
  localparam int CW_100FD = 8;
  localparam int CW_100HD = 7;
  localparam int CW_10FD = 6;
  localparam int CW_10HD = 5;
  localparam int CW_BITS = 16;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CTL_RST_VAL = 16'h2100;
  localparam logic [15:0] CTL_WR_MASK = 16'h3900;
  localparam logic [15:0] ADV_RST_VAL = 16'h01E1;
  localparam logic [15:0] STS_BASE = 16'h7840;
  // negotiation states
  typedef enum logic [2:0] {
    AN_IDLE = 3'h1,
    AN_SEND = 3'h2,
    AN_DONE = 3'h4
  } pmc_an_t;
endpackage

/* File: design/pmc_top.sv */
// phy mode control: duplex, negotiation, power down, leds, reset
// assumes pins arrive asynchronous to core_clk; sys_rst is the
// hardware reset pin, already inverted to active high
//
// Operation
// - full duplex ignores collision, crs on receive
// - half duplex flags collision, crs both directions
// - negotiation enabled by control bit or pin
// - bursts carry 16-bit word from advertisement
// - resolve highest common ability by priority
// - bursts after reset when enabled, else wait
// - negotiation off uses control speed and duplex
// - power down tri-states line, leds, mii
// - registers stay reachable while powered down
// - power down leaves on clear or reset
// - idle speed path is switched off outside negotiation
// - three-led mode speed, link/act, dup/col
// - four-led mode separate links plus activity
// - self-clearing soft reset raises reset-done
// - resets restore defaults and re-read straps
// - straps latched at reset, led pins then drive
// - status bit six reads one
// - frames without preamble accepted, one idle bit
// - local fault sets flag and renegotiates
// - partner fault flag sets status bit
`timescale 1ns/10ps
module pmc_top #(
  parameter int BLINK_CYC = pmc_pkg::BLINK_CYC,
  parameter int FLP_BIT_CYC = pmc_pkg::FLP_BIT_CYC,
  parameter int FLP_BURST_CYC = pmc_pkg::FLP_BURST_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mode_config_pin,
  input wire logic local_fault,
  input wire logic link_ok,
  input wire logic mii_tx_en,
  input wire logic rx_active,
  input wire logic lp_clk,
  input wire logic lp_dat,
  input wire logic lp_frame,
  output logic mii_crs,
  output logic mii_col,
  output logic mii_oe,
  output logic line_transmit_pair,
  output logic line_strobe,
  output logic line_oe,
  input wire logic [3:0] led_i,
  output logic [3:0] led_o,
  output logic [3:0] led_oe,
  output logic pwr100_en,
  output logic pwr10_en,
  output logic reset_done_output
);
  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (BLINK_CYC < 2 || FLP_BIT_CYC < 2 || FLP_BURST_CYC <
      FLP_BIT_CYC * pmc_pkg::CW_BITS) begin : g_chk
    $error("pmc_top: timing parameters too small");
  end

  function automatic logic [5:0] reg_idx(input logic [7:0] a);
    reg_idx = a[7:2];
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int NS = 9;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_ff;
  logic [NS-1:0] sync2_ff;
  assign pin_raw = {led_i[0], mode_config_pin, local_fault, link_ok,
                    mii_tx_en, rx_active, lp_clk, lp_dat, lp_frame};
  // first stage feeds only the second
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
    end
  end
  logic s_ledstrap, s_modecfg, s_fault, s_link, s_tx, s_rx;
  logic s_lpclk, s_lpdat, s_lpfrm;
  assign {s_ledstrap, s_modecfg, s_fault, s_link, s_tx, s_rx,
          s_lpclk, s_lpdat, s_lpfrm} = sync2_ff;

  // ------------------------------------------------------------
  // avalon slave, one wait cycle per access
  // ------------------------------------------------------------
  logic wait_ff, rd_acc, wr_acc;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [15:0] ctl_ff, adv_ff, lpa_ff;
  logic soft_rst_ff, lp_rf_ff, led4_ff, spd_ff, fd_ff;
  logic [1:0] strap_cnt_ff;
  pmc_pkg::pmc_an_t an_ff;
  assign rd_acc = avs_read && !wait_ff;
  assign wr_acc = avs_write && !wait_ff;
  // waitrequest drops for one cycle per request; no state touched
  // by power down, so access always works
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= '0;
    end else begin
      // back-to-back requests each get one wait cycle and need no idle gap
      wait_ff <= !(wait_ff && (avs_read || avs_write));
      rdata_ff <= nxt_rdata;
    end
  end
  // read mux; unmapped reads return zero
  always_comb begin
    nxt_rdata = '0;
    case (reg_idx(avs_address))
      pmc_pkg::IDX_CTL: nxt_rdata[15:0] = ctl_ff;
      pmc_pkg::IDX_STS: begin
        nxt_rdata[15:0] = pmc_pkg::STS_BASE;
        nxt_rdata[pmc_pkg::STS_ANC] = (an_ff == pmc_pkg::AN_DONE);
        nxt_rdata[pmc_pkg::STS_RF] = lp_rf_ff;
        nxt_rdata[pmc_pkg::STS_LNK] = s_link;
      end
      pmc_pkg::IDX_ADV: nxt_rdata[15:0] = adv_ff;
      pmc_pkg::IDX_LPA: nxt_rdata[15:0] = lpa_ff;
      pmc_pkg::IDX_MODE: nxt_rdata[4:0] = {led4_ff, spd_ff, fd_ff,
                                           (an_ff == pmc_pkg::AN_DONE),
                                           strap_cnt_ff == 2'h0};
      default: nxt_rdata = '0;
    endcase
  end
  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;

  // ------------------------------------------------------------
  // reset, soft reset and strap capture
  // ------------------------------------------------------------
  logic ctl_wr, strap_take;
  assign ctl_wr = wr_acc && reg_idx(avs_address) == pmc_pkg::IDX_CTL;
  // the syncs need their depth to fill after release, so straps
  // are taken only when the count reaches one
  assign strap_take = (strap_cnt_ff == 2'h1);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_rst_ff <= 1'b0;
      strap_cnt_ff <= 2'(pmc_pkg::STRAP_CNT);
      led4_ff <= 1'b0;
    end else begin
      soft_rst_ff <= ctl_wr && avs_writedata[pmc_pkg::CTL_RST];
      if (soft_rst_ff)
        strap_cnt_ff <= 2'(pmc_pkg::STRAP_CNT);
      else if (strap_cnt_ff != 2'h0)
        strap_cnt_ff <= strap_cnt_ff - 2'h1;
      if (strap_take)
        led4_ff <= s_ledstrap;
    end
  end
  // reset-done rises once straps are in and pins may drive
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      reset_done_output <= 1'b0;
    else
      reset_done_output <= (strap_cnt_ff == 2'h0) && !soft_rst_ff;
  end

  // ------------------------------------------------------------
  // control and advertisement registers
  // ------------------------------------------------------------
  logic an_en, pdn;
  assign an_en = ctl_ff[pmc_pkg::CTL_ANE];
  assign pdn = ctl_ff[pmc_pkg::CTL_PDN];
  // reset bit is never stored, so it reads back as zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_ff <= pmc_pkg::CTL_RST_VAL;
      adv_ff <= pmc_pkg::ADV_RST_VAL;
    end else if (soft_rst_ff) begin
      ctl_ff <= pmc_pkg::CTL_RST_VAL;
      adv_ff <= pmc_pkg::ADV_RST_VAL;
    end else begin
      if (strap_take)
        ctl_ff[pmc_pkg::CTL_ANE] <= s_modecfg;
      else if (ctl_wr && !avs_writedata[pmc_pkg::CTL_RST])
        ctl_ff <= avs_writedata[15:0] & pmc_pkg::CTL_WR_MASK;
      if (wr_acc && reg_idx(avs_address) == pmc_pkg::IDX_ADV)
        adv_ff <= avs_writedata[15:0];
    end
  end

  // ------------------------------------------------------------
  // partner code word receiver
  // ------------------------------------------------------------
  logic lpclk_d_ff, lp_word_vld;
  logic [15:0] lp_sh_ff;
  logic [4:0] lp_cnt_ff;
  // bits shift on the sampled partner clock's rising edge; the
  // frame signal resyncs the count so a broken burst is dropped
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lpclk_d_ff <= 1'b0;
      lp_sh_ff <= '0;
      lp_cnt_ff <= '0;
    end else begin
      lpclk_d_ff <= s_lpclk;
      if (!s_lpfrm || lp_word_vld)
        lp_cnt_ff <= '0;
      else if (s_lpclk && !lpclk_d_ff) begin
        lp_sh_ff <= {s_lpdat, lp_sh_ff[15:1]};
        lp_cnt_ff <= lp_cnt_ff + 5'h1;
      end
    end
  end
  assign lp_word_vld = (lp_cnt_ff == 5'(pmc_pkg::CW_BITS));

  // ------------------------------------------------------------
  // negotiation state machine and remote fault
  // ------------------------------------------------------------
  logic fault_d_ff, fault_rise, rf_flag_ff, an_go;
  assign fault_rise = s_fault && !fault_d_ff;
  assign an_go = an_en && !pdn && reset_done_output;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      an_ff <= pmc_pkg::AN_IDLE;
    else if (soft_rst_ff)
      an_ff <= pmc_pkg::AN_IDLE;
    else begin
      case (an_ff)
        pmc_pkg::AN_IDLE:
          if (an_go)
            an_ff <= pmc_pkg::AN_SEND;
        pmc_pkg::AN_SEND:
          if (!an_go)
            an_ff <= pmc_pkg::AN_IDLE;
          else if (lp_word_vld)
            an_ff <= pmc_pkg::AN_DONE;
        pmc_pkg::AN_DONE:
          if (!an_go)
            an_ff <= pmc_pkg::AN_IDLE;
          else if (fault_rise)
            an_ff <= pmc_pkg::AN_SEND;
        default: an_ff <= pmc_pkg::AN_IDLE;
      endcase
    end
  end
  // fault flag: a new fault wins over the clear from success
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_d_ff <= 1'b0;
      rf_flag_ff <= 1'b0;
      lp_rf_ff <= 1'b0;
      lpa_ff <= '0;
    end else begin
      fault_d_ff <= s_fault;
      if (fault_rise)
        rf_flag_ff <= 1'b1;
      else if (soft_rst_ff || (an_ff == pmc_pkg::AN_SEND && lp_word_vld))
        rf_flag_ff <= 1'b0;
      if (lp_word_vld && lp_sh_ff[pmc_pkg::CW_RF])
        lp_rf_ff <= 1'b1;
      else if (soft_rst_ff ||
               (rd_acc && reg_idx(avs_address) == pmc_pkg::IDX_STS))
        lp_rf_ff <= 1'b0;
      if (soft_rst_ff)
        lpa_ff <= '0;
      else if (lp_word_vld)
        lpa_ff <= lp_sh_ff;
    end
  end

  // ------------------------------------------------------------
  // fast link pulse burst generator
  // ------------------------------------------------------------
  logic [31:0] burst_cnt_ff, bit_cnt_ff;
  logic [4:0] bit_idx_ff;
  logic [15:0] tx_word;
  logic sending;
  assign sending = (an_ff == pmc_pkg::AN_SEND);
  always_comb begin
    tx_word = adv_ff;
    tx_word[pmc_pkg::CW_RF] = adv_ff[pmc_pkg::CW_RF] | rf_flag_ff;
  end
  // one word bit per pulse slot, then quiet until the next burst
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      burst_cnt_ff <= '0;
      bit_cnt_ff <= '0;
      bit_idx_ff <= '0;
      line_transmit_pair <= 1'b0;
      line_strobe <= 1'b0;
      line_oe <= 1'b0;
    end else begin
      line_oe <= !pdn && reset_done_output;
      line_strobe <= 1'b0;
      if (!sending) begin
        burst_cnt_ff <= '0;
        bit_cnt_ff <= '0;
        bit_idx_ff <= '0;
        line_transmit_pair <= 1'b0;
      end else begin
        burst_cnt_ff <= (burst_cnt_ff == 32'(FLP_BURST_CYC - 1)) ?
                        '0 : burst_cnt_ff + 32'h1;
        if (burst_cnt_ff == 32'h0) begin
          bit_idx_ff <= '0;
          bit_cnt_ff <= '0;
        end else if (bit_cnt_ff == 32'(FLP_BIT_CYC - 1)) begin
          bit_cnt_ff <= '0;
          if (bit_idx_ff != 5'(pmc_pkg::CW_BITS))
            bit_idx_ff <= bit_idx_ff + 5'h1;
        end else
          bit_cnt_ff <= bit_cnt_ff + 32'h1;
        if (bit_idx_ff != 5'(pmc_pkg::CW_BITS)) begin
          line_transmit_pair <= tx_word[bit_idx_ff[3:0]];
          line_strobe <= (bit_cnt_ff == 32'h0);
        end else
          line_transmit_pair <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // speed and duplex resolution, mii status, power paths
  // ------------------------------------------------------------
  logic [15:0] common;
  logic nxt_spd, nxt_fd;
  assign common = adv_ff & lpa_ff;
  always_comb begin
    nxt_spd = ctl_ff[pmc_pkg::CTL_SPD];
    nxt_fd = ctl_ff[pmc_pkg::CTL_DUP];
    if (an_en) begin
      nxt_spd = common[pmc_pkg::CW_100FD] | common[pmc_pkg::CW_100HD];
      nxt_fd = common[pmc_pkg::CW_100FD] | (!nxt_spd &&
               common[pmc_pkg::CW_10FD]);
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spd_ff <= 1'b0;
      fd_ff <= 1'b0;
      mii_crs <= 1'b0;
      mii_col <= 1'b0;
      mii_oe <= 1'b0;
      pwr100_en <= 1'b0;
      pwr10_en <= 1'b0;
    end else begin
      spd_ff <= nxt_spd;
      fd_ff <= nxt_fd;
      mii_crs <= fd_ff ? s_rx : (s_rx || s_tx);
      mii_col <= !fd_ff && s_rx && s_tx;
      mii_oe <= !pdn && reset_done_output;
      // both paths stay up while negotiation is still in flight
      pwr100_en <= !pdn && (spd_ff || sending);
      pwr10_en <= !pdn && (!spd_ff || sending);
    end
  end

  // ------------------------------------------------------------
  // led blink timers and display modes
  // ------------------------------------------------------------
  logic [31:0] blink_cnt_ff;
  logic blink20_ff, blink10_ff, act, coll;
  assign act = s_rx || s_tx;
  assign coll = !fd_ff && s_rx && s_tx;
  // 10 Hz derived from the 20 Hz toggle so the two stay in phase
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt_ff <= '0;
      blink20_ff <= 1'b0;
      blink10_ff <= 1'b0;
    end else if (blink_cnt_ff == 32'(BLINK_CYC - 1)) begin
      blink_cnt_ff <= '0;
      blink20_ff <= !blink20_ff;
      if (blink20_ff)
        blink10_ff <= !blink10_ff;
    end else
      blink_cnt_ff <= blink_cnt_ff + 32'h1;
  end
  // strap pins turn into led drivers only after reset-done
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_o <= '0;
      led_oe <= '0;
    end else begin
      led_oe <= {4{!pdn && reset_done_output}};
      led_o[3] <= led4_ff && (coll ? blink20_ff : fd_ff);
      if (led4_ff) begin
        led_o[0] <= s_link && spd_ff;
        led_o[1] <= s_link && !spd_ff;
        led_o[2] <= act && blink10_ff;
      end else begin
        led_o[0] <= spd_ff;
        led_o[1] <= s_link && (act && !coll ? blink10_ff : 1'b1);
        led_o[2] <= coll ? blink20_ff : fd_ff;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_soft_req;
    ctl_wr && avs_writedata[pmc_pkg::CTL_RST];
  endsequence
  sequence s_soft_done;
    soft_rst_ff ##1 (!ctl_ff[pmc_pkg::CTL_RST] && !reset_done_output)
    ##[1:5] reset_done_output;
  endsequence
  AST_SOFT_RST: assert property (@(posedge core_clk)
    disable iff (sys_rst) s_soft_req |=> s_soft_done)
    else $error("soft reset did not complete");
  AST_FD_NO_COL: assert property (@(posedge core_clk)
    disable iff (sys_rst) $past(fd_ff) |-> !mii_col)
    else $error("collision shown in full duplex");
  AST_HD_COL: assert property (@(posedge core_clk)
    disable iff (sys_rst) (!fd_ff && s_rx && s_tx) |=> mii_col && mii_crs)
    else $error("half duplex collision missed");
  AST_AN_START: assert property (@(posedge core_clk)
    disable iff (sys_rst) (an_ff == pmc_pkg::AN_IDLE && an_go &&
    !soft_rst_ff) |=> sending ##[1:2] line_strobe)
    else $error("negotiation did not start");
  AST_PDN: assert property (@(posedge core_clk)
    disable iff (sys_rst) pdn |=> !line_oe && !mii_oe && led_oe == '0)
    else $error("outputs driven in power down");
  AST_PRE: assert property (@(posedge core_clk)
    disable iff (sys_rst) (rd_acc && reg_idx(avs_address) ==
    pmc_pkg::IDX_STS) |=> avs_readdata[pmc_pkg::STS_PRE])
    else $error("preamble suppression bit low");
  AST_RF_CLR: assert property (@(posedge core_clk)
    disable iff (sys_rst) (sending && lp_word_vld && !fault_rise &&
    an_go && !soft_rst_ff)
    |=> !rf_flag_ff && an_ff == pmc_pkg::AN_DONE)
    else $error("fault flag kept after success");
  AST_LP_RF: assert property (@(posedge core_clk)
    disable iff (sys_rst) (lp_word_vld && lp_sh_ff[pmc_pkg::CW_RF])
    |=> lp_rf_ff)
    else $error("partner fault not recorded");
  AST_ACK: assert property (@(posedge core_clk)
    disable iff (sys_rst) (!wait_ff) |=> wait_ff)
    else $error("waitrequest low for two cycles");
endmodule

/* File: dv/phy_mode_control_test.sv */
// bench for phy mode control: registers, link words, mii, resets
// assumes a one-request avalon slave and the partner model beside it
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module phy_mode_control_test;
  logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic mode_config_pin, local_fault, link_ok, mii_tx_en, rx_active;
  logic lp_clk, lp_dat, lp_frame, mii_crs, mii_col, mii_oe;
  logic line_transmit_pair, line_strobe, line_oe;
  logic [3:0] led_i, led_o, led_oe;
  logic pwr100_en, pwr10_en, reset_done_output;
  logic [15:0] w;
  int error_cnt = 0, comparisons = 0, cyc = 0, n;
  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  // short counts keep bursts and blinks inside a quick run
  pmc_top #(.BLINK_CYC(8), .FLP_BIT_CYC(4), .FLP_BURST_CYC(100)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mode_config_pin(mode_config_pin),
    .local_fault(local_fault), .link_ok(link_ok), .mii_tx_en(mii_tx_en),
    .rx_active(rx_active), .lp_clk(lp_clk), .lp_dat(lp_dat),
    .lp_frame(lp_frame), .mii_crs(mii_crs), .mii_col(mii_col),
    .mii_oe(mii_oe), .line_transmit_pair(line_transmit_pair),
    .line_strobe(line_strobe), .line_oe(line_oe), .led_i(led_i),
    .led_o(led_o), .led_oe(led_oe), .pwr100_en(pwr100_en),
    .pwr10_en(pwr10_en), .reset_done_output(reset_done_output));
  pmc_lp_model lp_u (.lp_clk(lp_clk), .lp_dat(lp_dat), .lp_frame(lp_frame));
  // ------------------------------------------------------------
  // clock, timeout, verdict
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // the whole run needs well under this many cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // bus and line tasks
  // ------------------------------------------------------------
  // request held until waitrequest is seen low, released after that edge
  // a clock edge always separates two requests
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) error_cnt++;
    @(posedge core_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] m,
                     input logic [15:0] e, input string nm);
    acc(1'b0, a, 32'h0);
    `CHK(nm, e, q[15:0] & m)
  endtask
  // waits for a gap between bursts, then takes 16 bit slots
  task automatic get_word(output logic [15:0] v);
    int gap, k;
    gap = 0;
    k = 0;
    v = 16'h0000;
    while (gap < 8 && k < 3000) begin
      @(negedge core_clk);
      k++;
      gap = (line_strobe === 1'b1) ? 0 : gap + 1;
    end
    for (int i = 0; i < 16; i++) begin
      do begin
        @(negedge core_clk);
        k++;
      end while (line_strobe !== 1'b1 && k < 3000);
      v[i] = line_transmit_pair;
    end
  endtask
  task automatic mii(input logic t, input logic r, input logic cr,
                     input logic co, input string nm);
    mii_tx_en <= t;
    rx_active <= r;
    repeat (6) @(posedge core_clk);
    `CHK(nm, {cr, co}, {mii_crs, mii_col})
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 8'h00; avs_writedata = 32'h0; mode_config_pin = 1'b1;
    local_fault = 1'b0; link_ok = 1'b1; mii_tx_en = 1'b0;
    rx_active = 1'b0; led_i = 4'h0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    rdc(8'h00, 16'hFFFF, 16'h3100, "ctl");
    rdc(8'h04, 16'h0040, 16'h0040, "sts");
    rdc(8'h10, 16'hFFFF, 16'h01E1, "adv");
    rdc(8'h80, 16'hFFFF, 16'h0000, "unmapped");
    get_word(w);
    `CHK("flp word", 16'h01E1, w)
    lp_u.send(16'h0101);
    repeat (12) @(posedge core_clk);
    rdc(8'h04, 16'h0020, 16'h0020, "an done");
    rdc(8'h40, 16'h000C, 16'h000C, "100 full");
    lp_u.send(16'h0041);
    repeat (12) @(posedge core_clk);
    rdc(8'h40, 16'h000C, 16'h0004, "10 full");
    `CHK("pwr 10", 2'b01, {pwr100_en, pwr10_en})
    lp_u.send(16'h2021);
    repeat (12) @(posedge core_clk);
    rdc(8'h04, 16'h0010, 16'h0010, "partner fault");
    local_fault <= 1'b1;
    get_word(w);
    `CHK("fault word", 16'h21E1, w)
    lp_u.send(16'h0021);
    repeat (12) @(posedge core_clk);
    // negotiation is done now; cycle enable to see the next burst
    acc(1'b1, 8'h00, 32'h0100);
    acc(1'b1, 8'h00, 32'h1100);
    get_word(w);
    `CHK("fault cleared", 16'h01E1, w)
    acc(1'b1, 8'h00, 32'h2100);
    rdc(8'h40, 16'h001C, 16'h000C, "manual");
    `CHK("pwr 100", 2'b10, {pwr100_en, pwr10_en})
    `CHK("led3 off", 1'b0, led_o[3])
    n = 0;
    repeat (300) @(posedge core_clk) if (line_strobe === 1'b1) n++;
    `CHK("no bursts", 0, n)
    mii(1'b1, 1'b0, 1'b0, 1'b0, "fd tx");
    mii(1'b1, 1'b1, 1'b1, 1'b0, "fd both");
    acc(1'b1, 8'h00, 32'h2000);
    mii(1'b1, 1'b1, 1'b1, 1'b1, "hd both");
    mii(1'b1, 1'b0, 1'b1, 1'b0, "hd tx");
    acc(1'b1, 8'h00, 32'h2900);
    repeat (2) @(posedge core_clk);
    `CHK("pdn oe", 6'h00, {line_oe, mii_oe, led_oe})
    rdc(8'h00, 16'hFFFF, 16'h2900, "pdn read");
    acc(1'b1, 8'h00, 32'h2100);
    repeat (4) @(posedge core_clk);
    `CHK("pdn exit", 1'b1, mii_oe)
    acc(1'b1, 8'h00, 32'h2900);
    led_i <= 4'h1;
    mode_config_pin <= 1'b0;
    acc(1'b1, 8'h00, 32'h8000);
    repeat (8) @(posedge core_clk);
    `CHK("reset done", 1'b1, reset_done_output)
    rdc(8'h00, 16'hFFFF, 16'h2100, "soft rst ctl");
    rdc(8'h40, 16'h0010, 16'h0010, "four led");
    `CHK("led 100 link", 1'b1, led_o[0])
    link_ok <= 1'b0;
    repeat (6) @(posedge core_clk);
    `CHK("led link lost", 2'b00, led_o[1:0])
    rdc(8'h04, 16'h0004, 16'h0000, "link down");
    end_sim();
  end
endmodule

/* File: dv/pmc_lp_model.sv */
// link partner model: shifts one 16-bit code word into the block
// assumes the block samples lp_clk with its own core clock
`timescale 1ns/10ps
module pmc_lp_model (
  output logic lp_clk,
  output logic lp_dat,
  output logic lp_frame
);
  // ------------------------------------------------------------
  // idle lines
  // ------------------------------------------------------------
  // link clock stands still outside frames
  initial begin
    lp_clk = 1'b0;
    lp_dat = 1'b0;
    lp_frame = 1'b0;
  end
  // ------------------------------------------------------------
  // word sender, 64 ns link clock, lsb first
  // ------------------------------------------------------------
  // data flips after the frame so a stale bit is never reused
  task automatic send(input logic [15:0] w);
    lp_frame = 1'b1;
    for (int i = 0; i < 16; i++) begin
      lp_dat = w[i];
      #32 lp_clk = 1'b1;
      #32 lp_clk = 1'b0;
    end
    #32 lp_frame = 1'b0;
    lp_dat = ~lp_dat;
  endtask
endmodule
